// *** rtl/pmrdp_pkg.sv ***
// ****************************************************************
// Shared constants and types of the MAC data port
// ****************************************************************
package pmrdp_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    // Period of the system clock, 20 MHz
    localparam int unsigned CLK_PERIOD_NS = 50;
    // Heartbeat pulse length after a 10 Mb/s transmission
    localparam int unsigned HB_TIME_NS    = 1000;
    // Heartbeat length in clocks; "about one microsecond", so truncate
    localparam logic [4:0]  HB_CYC        = 5'(HB_TIME_NS / CLK_PERIOD_NS);

    // Clocks per interface half period (MII) or per dibit slot (RMII)
    localparam logic [3:0]  DIV_100       = 4'h1;
    // Ten times slower for 10 Mb/s, as 2.5 MHz is to 25 MHz
    localparam logic [3:0]  DIV_10        = 4'ha;

    // ************************************************************
    // Receive buffer shape and data handling
    // ************************************************************
    localparam int unsigned FIFO_WIDTH    = 5;
    localparam int unsigned FIFO_DEPTH    = 4;
    // Bit of a buffer word that flags a symbol or media error
    localparam int unsigned ERR_BIT       = 4;
    // Pattern xored into a nibble delivered with an error
    localparam logic [3:0]  CORRUPT_MASK  = 4'hf;
    // Receive data value while no data is valid
    localparam logic [3:0]  RXD_IDLE      = 4'h0;

    // ************************************************************
    // Transmit side states, Gray coded along idle-active-heartbeat
    // ************************************************************
    typedef enum logic [1:0] {
        PMRDP_TX_IDLE   = 2'b00,
        PMRDP_TX_ACTIVE = 2'b01,
        PMRDP_TX_HB     = 2'b11
    } pmrdp_tx_state_t;

    // Whole state of the port
    typedef struct packed {
        logic [3:0]      div_cnt;       // Rate divider
        logic            clk_ph;        // Phase of the MII clocks
        logic            tx_clk;        // Transmit clock pin
        logic            rx_clk;        // Receive clock pin
        pmrdp_tx_state_t tx_st;         // Transmit activity
        logic [4:0]      hb_cnt;        // Heartbeat length left
        logic            tx_hi;         // Next RMII dibit is the upper one
        logic [1:0]      tx_lo;         // Held lower RMII dibit
        logic            line_tx_valid; // Nibble strobe to the line side
        logic [3:0]      line_tx_data;  // Nibble to the line side
        logic            rx_hi;         // Next RMII dibit sent is the upper one
        logic            rx_dv;         // Receive data valid pin
        logic            rx_er;         // Receive error pin
        logic [3:0]      rxd;           // Receive data pins
        logic            crs;           // Carrier sense, or CRS_DV in RMII
        logic            col;           // Collision pin
    } pmrdp_state_t;

    localparam pmrdp_state_t PMRDP_STATE_RST = '0;

endpackage

// *** rtl/pmrdp_fifo.sv ***
`timescale 1ns/100ps
// ****************************************************************
// Small synchronous FIFO with valid/ready on both sides
// ****************************************************************
module pmrdp_fifo #(
    parameter int unsigned WIDTH = 5,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);

    // Depth must be a power of two so the pointers wrap by themselves
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;    // Storage
        logic [AW-1:0]               wp;     // Write pointer
        logic [AW-1:0]               rp;     // Read pointer
        logic [AW:0]                 cnt;    // Words held
        logic                        room;   // Not full
        logic                        nempty; // Not empty
    } pmrdp_fifo_state_t;

    pmrdp_fifo_state_t s_q;   // Registered state
    pmrdp_fifo_state_t s_d;   // Next state
    logic              push;  // Word accepted
    logic              pop;   // Word taken

    // ************************************************************
    // Next state
    // ************************************************************
    // Flags are registered from the next count, so ready is a flop
    always_comb begin
        s_d  = s_q;
        push = in_valid & s_q.room;
        pop  = out_ready & s_q.nempty;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp          = s_q.wp + AW'(1);
        end
        if (pop) begin
            s_d.rp = s_q.rp + AW'(1);
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - (AW+1)'(1);
        end
        s_d.room   = (s_d.cnt != (AW+1)'(DEPTH));
        s_d.nempty = (s_d.cnt != '0);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.room <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready  = s_q.room;
    assign out_valid = s_q.nempty;
    assign out_data  = s_q.mem[s_q.rp];

endmodule

// *** rtl/pmrdp_port.sv ***
`timescale 1ns/100ps
// Summary of operation
// - MII transmit clock at 25 or 2.5 MHz; here clk/2 or clk/20
// - RMII: interface clocks unused, reference times all
// - MII transmit nibbles taken on transmit clock
// - RMII transmit dibits taken on reference clock
// - MII receive clock at 25 or 2.5 MHz; here clk/2 or clk/20
// - MII receive nibbles, RX_DV only while valid
// - RMII data valid independent of carrier sense
// - MII 100 Mb/s: RX_ER on invalid symbol
// - RMII 100 Mb/s: RX_ER on error while valid
// - Receive error also corrupts delivered data
// - RMII receive data two bits on reference
// - MII CRS high while medium not idle
// - RMII CRS_DV merges carrier and data valid
// - MII half duplex: COL on simultaneous activity
// - 10 Mb/s heartbeat: COL pulse after transmit
// - Full duplex: COL low, no heartbeat
module pmrdp_port
    import pmrdp_pkg::*;
(
    input  wire logic       clk,           // Reference clock
    input  wire logic       rst,           // Synchronous reset
    // Mode selection
    input  wire logic       rmii_mode,     // Two-bit reduced mode
    input  wire logic       speed_100,     // 100 Mb/s, else 10 Mb/s
    input  wire logic       full_duplex,   // Full duplex operation
    input  wire logic       heartbeat_en,  // SQE test at 10 Mb/s
    // MAC side
    input  wire logic       tx_en,         // Transmit enable
    input  wire logic [3:0] txd,           // Transmit data
    output logic            tx_clk,        // MII transmit clock
    output logic            rx_clk,        // MII receive clock
    output logic            rx_dv,         // Receive data valid
    output logic            rx_er,         // Receive error
    output logic [3:0]      rxd,           // Receive data
    output logic            crs,           // Carrier sense or CRS_DV
    output logic            col,           // Collision
    // Line side, receive
    input  wire logic       line_carrier,  // Receive medium not idle
    input  wire logic       line_rx_valid, // Received nibble offered
    input  wire logic [3:0] line_rx_data,  // Received nibble
    input  wire logic       line_rx_err,   // Nibble had a bad symbol
    output logic            line_rx_ready, // Buffer has room
    // Line side, transmit
    output logic            line_tx_valid, // One-cycle nibble strobe
    output logic [3:0]      line_tx_data,  // Nibble to send
    output logic            line_tx_active // Transmission in progress
);

    // ************************************************************
    // Declarations
    // ************************************************************
    pmrdp_state_t          s_q;      // Registered state
    pmrdp_state_t          s_d;      // Next state
    logic [3:0]            div_lim;  // Clocks per tick at this speed
    logic                  tick;     // Divider wrap
    logic                  mii_rise; // MII clocks go high now
    logic                  slot;     // RMII dibit slot
    logic                  samp;     // Interface sampling instant
    logic                  hb_ok;    // Heartbeat wanted at end of frame
    logic                  half_mii; // COL may be driven at all
    logic                  fifo_rdy; // Buffer entry leaves this cycle
    logic                  fifo_vld; // Buffer holds a word
    logic [FIFO_WIDTH-1:0] fifo_out; // Oldest buffered word
    logic [3:0]            rx_nib;   // Nibble after corruption
    logic                  rx_bad;   // Oldest word carries an error
    logic [1:0]            rx_dib;   // RMII dibit to launch

    // ************************************************************
    // Receive buffer between line decoder and MAC pins
    // ************************************************************
    // The line side can run ahead of the interface clock by four
    // nibbles; beyond that it is held off through line_rx_ready.
    pmrdp_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (line_rx_valid),
        .in_data   ({line_rx_err, line_rx_data}),
        .in_ready  (line_rx_ready),
        .out_valid (fifo_vld),
        .out_data  (fifo_out),
        .out_ready (fifo_rdy)
    );

    // ************************************************************
    // Rate ticks
    // ************************************************************
    // One counter serves both modes: MII half periods and RMII slots
    // happen to need the same spacing at each speed.
    always_comb begin
        div_lim  = speed_100 ? DIV_100 : DIV_10;
        tick     = (s_q.div_cnt == (div_lim - 4'h1));
        mii_rise = tick & ~s_q.clk_ph & ~rmii_mode;
        slot     = tick & rmii_mode;
        samp     = mii_rise | slot;
        hb_ok    = heartbeat_en & ~speed_100 & ~full_duplex;
        half_mii = ~rmii_mode & ~full_duplex;
    end

    // ************************************************************
    // Receive word shaping
    // ************************************************************
    // Data is spoiled as well as flagged, so a MAC that never looks
    // at RX_ER still fails the frame check.
    always_comb begin
        rx_bad = fifo_out[ERR_BIT];
        rx_nib = fifo_out[3:0];
        if (rx_bad) begin
            rx_nib = fifo_out[3:0] ^ CORRUPT_MASK;
        end
        rx_dib = s_q.rx_hi ? rx_nib[3:2] : rx_nib[1:0];
        // MII frees a word per nibble, RMII after its upper dibit
        fifo_rdy = samp & fifo_vld & (~rmii_mode | s_q.rx_hi);
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;

        // Strobe to the line side lasts one cycle
        s_d.line_tx_valid = 1'b0;

        // Divider and MII clock phase
        if (tick) begin
            s_d.div_cnt = 4'h0;
            s_d.clk_ph  = ~s_q.clk_ph;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 4'h1;
        end

        // Clock pins; parked low in RMII where they have no use
        if (rmii_mode) begin
            s_d.tx_clk = 1'b0;
            s_d.rx_clk = 1'b0;
            s_d.clk_ph = 1'b0;
        end else begin
            s_d.tx_clk = s_d.clk_ph;
            // No recovery loop here; the receive clock shares the rate
            s_d.rx_clk = s_d.clk_ph;
        end

        // ********************************************************
        // Transmit path
        // ********************************************************
        if (samp && tx_en) begin
            if (!rmii_mode) begin
                // Whole nibble each rising transmit clock
                s_d.line_tx_valid = 1'b1;
                s_d.line_tx_data  = txd;
            end else if (!s_q.tx_hi) begin
                // Lower dibit first, hold it for its partner
                s_d.tx_lo = txd[1:0];
                s_d.tx_hi = 1'b1;
            end else begin
                s_d.line_tx_valid = 1'b1;
                s_d.line_tx_data  = {txd[1:0], s_q.tx_lo};
                s_d.tx_hi         = 1'b0;
            end
        end else if (samp) begin
            // Odd dibit at frame end is dropped
            s_d.tx_hi = 1'b0;
        end

        // Transmit activity and heartbeat
        unique case (s_q.tx_st)
            PMRDP_TX_IDLE: begin
                if (samp && tx_en) begin
                    s_d.tx_st = PMRDP_TX_ACTIVE;
                end
            end
            PMRDP_TX_ACTIVE: begin
                if (samp && !tx_en) begin
                    if (hb_ok && !rmii_mode) begin
                        // SQE test follows the end of every frame
                        s_d.tx_st  = PMRDP_TX_HB;
                        s_d.hb_cnt = HB_CYC;
                    end else begin
                        s_d.tx_st = PMRDP_TX_IDLE;
                    end
                end
            end
            PMRDP_TX_HB: begin
                if (samp && tx_en) begin
                    // A new frame cuts the heartbeat short
                    s_d.tx_st  = PMRDP_TX_ACTIVE;
                    s_d.hb_cnt = 5'h00;
                end else if (s_q.hb_cnt == 5'h01) begin
                    s_d.tx_st  = PMRDP_TX_IDLE;
                    s_d.hb_cnt = 5'h00;
                end else begin
                    s_d.hb_cnt = s_q.hb_cnt - 5'h01;
                end
            end
            default: begin
                // Unused code 10 returns to idle
                s_d.tx_st  = PMRDP_TX_IDLE;
                s_d.hb_cnt = 5'h00;
            end
        endcase

        // ********************************************************
        // Receive path
        // ********************************************************
        if (samp) begin
            if (fifo_vld) begin
                // Valid only while a buffered word is on the pins
                s_d.rx_dv = 1'b1;
                if (rmii_mode) begin
                    // Two bits wide, no relation to carrier state
                    s_d.rxd   = {2'b00, rx_dib};
                    s_d.rx_hi = ~s_q.rx_hi;
                    s_d.rx_er = rx_bad & speed_100;
                end else begin
                    s_d.rxd   = rx_nib;
                    s_d.rx_hi = 1'b0;
                    s_d.rx_er = rx_bad & speed_100;
                end
            end else begin
                s_d.rx_dv = 1'b0;
                s_d.rx_er = 1'b0;
                s_d.rxd   = RXD_IDLE;
                s_d.rx_hi = 1'b0;
            end
        end

        // ********************************************************
        // Carrier sense
        // ********************************************************
        if (!rmii_mode) begin
            // Follows the medium, not the receive clock
            s_d.crs = line_carrier;
        end else if (slot) begin
            // Carrier, or data still draining from the buffer
            s_d.crs = line_carrier | fifo_vld;
        end

        // ********************************************************
        // Collision
        // ********************************************************
        // RMII has no collision pin duty; the MAC works it out
        if (!half_mii) begin
            s_d.col = 1'b0;
        end else begin
            s_d.col = ((s_d.tx_st == PMRDP_TX_ACTIVE) & line_carrier)
                    | (s_d.tx_st == PMRDP_TX_HB);
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= PMRDP_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs, each a field of the state register except line_tx_active, decoded from tx_st
    // ************************************************************
    assign tx_clk         = s_q.tx_clk;
    assign rx_clk         = s_q.rx_clk;
    assign rx_dv          = s_q.rx_dv;
    assign rx_er          = s_q.rx_er;
    assign rxd            = s_q.rxd;
    assign crs            = s_q.crs;
    assign col            = s_q.col;
    assign line_tx_valid  = s_q.line_tx_valid;
    assign line_tx_data   = s_q.line_tx_data;
    assign line_tx_active = (s_q.tx_st == PMRDP_TX_ACTIVE);

endmodule

// *** dv/pmrdp_port_assertions.sv ***
`timescale 1ns/100ps
// ****************************
// Port timing checker
// ****************************
module pmrdp_port_chk (
    input logic       clk,
    input logic       rst,
    input logic       rmii_mode,
    input logic       speed_100,
    input logic       full_duplex,
    input logic       heartbeat_en,
    input logic       tx_clk,
    input logic       rx_clk,
    input logic       rx_er,
    input logic [3:0] rxd,
    input logic       crs,
    input logic       col,
    input logic       line_carrier,
    input logic       line_tx_valid,
    input logic       line_tx_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // End of a 10 Mb/s half duplex frame with SQE test on
    sequence s_hb_end;
        !rmii_mode && !speed_100 && !full_duplex && heartbeat_en && $fell(line_tx_active);
    endsequence
    // SQE pulse; only the first cycles, the full length is counted by the bench
    sequence s_hb_pulse;
        col [*8];
    endsequence
    property p_hb;
        s_hb_end |-> ##[0:2] s_hb_pulse;
    endproperty
    property p_clk100;
        !rmii_mode && speed_100 && tx_clk |=> !tx_clk;
    endproperty
    property p_clk10;
        !rmii_mode && !speed_100 && $rose(tx_clk) |-> tx_clk [*8] ##1 tx_clk ##1 tx_clk ##1 !tx_clk;
    endproperty
    property p_same;
        tx_clk == rx_clk;
    endproperty
    property p_rmii_pins;
        rmii_mode |-> !tx_clk && !rx_clk && rxd[3:2] == 2'h0;
    endproperty
    property p_no_col;
        full_duplex || rmii_mode |-> !col;
    endproperty
    property p_col;
        // col follows the next transmit state, so it drops with the frame's end
        !rmii_mode && !full_duplex && line_carrier ##1 line_tx_active |-> col;
    endproperty
    property p_crs;
        !rmii_mode |=> crs == $past(line_carrier);
    endproperty
    property p_crs_dv;
        rmii_mode && speed_100 && line_carrier |=> crs;
    endproperty
    property p_er10;
        !speed_100 |-> !rx_er;
    endproperty
    property p_pulse;
        line_tx_valid |=> !line_tx_valid;
    endproperty
    a_hb: assert property (p_hb) else $error("no heartbeat pulse");
    a_clk100: assert property (p_clk100) else $error("bad fast clock");
    a_clk10: assert property (p_clk10) else $error("bad slow clock");
    a_same: assert property (p_same) else $error("clocks differ");
    a_rmii_pins: assert property (p_rmii_pins) else $error("unused pins move");
    a_no_col: assert property (p_no_col) else $error("collision in full duplex");
    a_col: assert property (p_col) else $error("collision missed");
    a_crs: assert property (p_crs) else $error("carrier sense wrong");
    a_crs_dv: assert property (p_crs_dv) else $error("merged carrier wrong");
    a_er10: assert property (p_er10) else $error("error flag at low speed");
    a_pulse: assert property (p_pulse) else $error("strobe too long");
endmodule

bind pmrdp_port pmrdp_port_chk u_chk (.clk(clk), .rst(rst), .rmii_mode(rmii_mode),
    .speed_100(speed_100), .full_duplex(full_duplex), .heartbeat_en(heartbeat_en),
    .tx_clk(tx_clk), .rx_clk(rx_clk), .rx_er(rx_er), .rxd(rxd), .crs(crs), .col(col),
    .line_carrier(line_carrier), .line_tx_valid(line_tx_valid),
    .line_tx_active(line_tx_active));

// *** dv/pmrdp_mac_model.sv ***
`timescale 1ns/100ps
// ****************************
// Transmitting MAC
// ****************************
module pmrdp_mac_model (
    input  logic       clk,
    input  logic       rmii_mode,
    input  logic       speed_100,
    input  logic       tx_clk,
    output logic       tx_en,
    output logic [3:0] txd
);
    initial begin
        tx_en = 1'b0;
        txd = 4'h0;
    end
    // One nibble; changes only after the edge that took the last one
    task automatic send_nib(input logic [3:0] n);
        if (!rmii_mode) begin
            @(posedge tx_clk);
            @(negedge clk);
            tx_en = 1'b1;
            txd = n;
        end else begin
            // Lower dibit first, each held one slot of the reference
            for (int h = 0; h < 2; h++) begin
                @(negedge clk);
                tx_en = 1'b1;
                txd = {2'h0, h ? n[3:2] : n[1:0]};
                repeat (speed_100 ? 0 : 9) @(negedge clk);
            end
        end
    endtask
    // Ends the frame; released data shows the inverse, not the last value
    task automatic stop();
        if (!rmii_mode) @(posedge tx_clk);
        @(negedge clk);
        tx_en = 1'b0;
        txd = ~txd;
    endtask
endmodule

// *** dv/tb_phy_mii_rmii_data_port.sv ***
`timescale 1ns/100ps
module tb_phy_mii_rmii_data_port;
    import pmrdp_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       rmii_mode = 1'b0, speed_100 = 1'b0, full_duplex = 1'b0, heartbeat_en = 1'b0;
    logic       tx_en, tx_clk, rx_clk, rx_dv, rx_er, crs, col, line_rx_ready;
    logic [3:0] txd, rxd, line_tx_data;
    logic       line_carrier = 1'b0, line_rx_valid = 1'b0, line_rx_err = 1'b0;
    logic [3:0] line_rx_data = 4'h0;
    logic       line_tx_valid, line_tx_active, saw_full, prv;
    logic [3:0] exp_tx[$];
    logic [4:0] exp_rx[$];
    logic [1:0] hbt[3] = '{2'b01, 2'b11, 2'b00};
    int         miscompares = 0, check_count = 0, cyc = 0, cnt;
    // ****************************
    // Clock, device and MAC
    // ****************************
    initial forever #25 clk = ~clk;
    pmrdp_port uut (.clk(clk), .rst(rst), .rmii_mode(rmii_mode), .speed_100(speed_100),
        .full_duplex(full_duplex), .heartbeat_en(heartbeat_en), .tx_en(tx_en), .txd(txd),
        .tx_clk(tx_clk), .rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
        .crs(crs), .col(col), .line_carrier(line_carrier), .line_rx_valid(line_rx_valid),
        .line_rx_data(line_rx_data), .line_rx_err(line_rx_err),
        .line_rx_ready(line_rx_ready), .line_tx_valid(line_tx_valid),
        .line_tx_data(line_tx_data), .line_tx_active(line_tx_active));
    pmrdp_mac_model mac (.clk(clk), .rmii_mode(rmii_mode), .speed_100(speed_100),
        .tx_clk(tx_clk), .tx_en(tx_en), .txd(txd));
    // ****************************
    // Checking and closing
    // ****************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard, far above the thousand or so cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    // Line nibble strobe: read pre-edge, so each pulse is seen once
    always @(posedge clk) begin
        if (line_tx_valid === 1'b1) begin
            if (exp_tx.size() == 0) check(8'h1, 8'h0, "extra nibble");
            else check({4'h0, line_tx_data}, {4'h0, exp_tx.pop_front()}, "tx");
        end
    end
    // Receive unit: per clock rise in MII, per slot in fast RMII
    always @(posedge clk) begin
        if ((rmii_mode || (rx_clk === 1'b1 && prv === 1'b0)) && rx_dv === 1'b1) begin
            if (exp_rx.size() == 0) check(8'h1, 8'h0, "extra rx unit");
            else check({3'h0, rx_er, rxd}, {3'h0, exp_rx.pop_front()}, "rx");
        end
        prv = rx_clk;
    end
    // ****************************
    // Stimulus tasks
    // ****************************
    // Modes change only under reset, since they are static during frames
    task automatic do_reset(input logic [3:0] m);
        @(negedge clk);
        rst = 1'b1;
        {rmii_mode, speed_100, full_duplex, heartbeat_en} = m;
        repeat (12) @(negedge clk);
        check({2'h0, rx_dv, rx_er, col, crs, line_rx_ready, line_tx_valid}, 8'h02, "reset");
        rst = 1'b0;
    endtask
    task automatic tx_frame(input int n);
        logic [3:0] d;
        for (int i = 0; i < n; i++) begin
            d = 4'($urandom);
            exp_tx.push_back(d);
            mac.send_nib(d);
        end
        mac.stop();
        for (int i = 0; i < 60 && exp_tx.size() > 0; i++) @(posedge clk);
        @(negedge clk);
    endtask
    // Line side offers back to back, so the four word buffer must refuse
    task automatic rx_frame(input int n);
        logic [3:0] d;
        logic       e;
        logic [4:0] x;
        saw_full = 1'b0;
        line_carrier = 1'b1;
        for (int i = 0; i < n; i++) begin
            d = 4'($urandom);
            e = ($urandom % 4) == 0;
            x = {e & speed_100, e ? d ^ CORRUPT_MASK : d};
            if (!rmii_mode) exp_rx.push_back(x);
            else begin
                exp_rx.push_back({x[4], 2'h0, x[1:0]});
                exp_rx.push_back({x[4], 2'h0, x[3:2]});
            end
            line_rx_valid = 1'b1;
            line_rx_data = d;
            line_rx_err = e;
            @(posedge clk);
            while (line_rx_ready !== 1'b1) begin
                saw_full = 1'b1;
                @(posedge clk);
            end
            @(negedge clk);
        end
        line_rx_valid = 1'b0;
        line_rx_data = ~line_rx_data;
        for (int i = 0; i < 400 && exp_rx.size() > 0; i++) @(posedge clk);
        @(negedge clk);
        line_carrier = 1'b0;
        check({7'h0, saw_full}, 8'h01, "no refusal");
        check(8'(exp_rx.size()), 8'h00, "rx lost");
    endtask
    // ****************************
    // Main sequence
    // ****************************
    initial begin
        void'($urandom(50));
        // All four mode and speed pairs, with carrier during transmit
        for (int c = 0; c < 4; c++) begin
            do_reset({c[1], c[0], 2'b00});
            line_carrier = 1'b1;
            tx_frame(6);
            line_carrier = 1'b0;
            check(8'(exp_tx.size()), 8'h00, "tx lost");
            if (c != 2) rx_frame(8);
        end
        // Heartbeat only in half duplex with the test enabled
        for (int h = 0; h < 3; h++) begin
            do_reset({2'b00, hbt[h]});
            tx_frame(2);
            cnt = 0;
            repeat (80) @(posedge clk) if (col === 1'b1) cnt++;
            check(8'(cnt), h == 0 ? 8'(HB_TIME_NS / CLK_PERIOD_NS) : 8'h0, "sqe");
        end
        complete_run();
    end
endmodule
